// ===== shared/bhd_pkg.sv
package bhd_pkg;
    // address decode widths
    localparam int BHD_BUS_ID_W = 10;
    localparam int BHD_SLOT_W = 4;
    localparam int BHD_SUBM_W = 2;
    localparam int BHD_NUM_SLOTS = 6;
    localparam int BHD_MASTER_W = 3;
    // register space sits in the top one of the 16 address pages
    localparam logic [3:0] BHD_SPACE_TOP = 4'hF;
    localparam int BHD_SPACE_TOP_LSB = 28;
    localparam int BHD_ID_LSB = 18;
    localparam int BHD_SLOT_LSB = 14;
    localparam int BHD_SUBM_LSB = 12;
    localparam int BHD_OFF_W = 12;
    // register offsets inside the 4K register space
    localparam logic [11:0] BHD_OFF_FEAT = 12'h820;
    localparam logic [11:0] BHD_OFF_RDHINT = 12'h824;
    localparam logic [11:0] BHD_OFF_WRHINT = 12'h828;
    localparam logic [11:0] BHD_OFF_EXTARB = 12'h82C;
    localparam logic [11:0] BHD_OFF_STATUS = 12'h840;
    // reset values
    localparam logic [31:0] BHD_RST_FEAT = 32'h0000_0000;
    localparam logic [31:0] BHD_RST_RDHINT = 32'h0000_0000;
    localparam logic [31:0] BHD_RST_WRHINT = 32'h0000_0000;
    localparam logic [5:0] BHD_RST_EXTARB = 6'h00;
    // field layout: read fields 4 wide, write fields 2 wide, 4-bit stride
    localparam int BHD_RD_FIELD_W = 4;
    localparam int BHD_WR_FIELD_W = 2;
    localparam int BHD_FIELD_STRIDE = 4;
    localparam logic [31:0] BHD_RDHINT_MASK = 32'h00FF_FFFF;
    localparam logic [31:0] BHD_WRHINT_MASK = 32'h0033_3333;
    // feature enable bit positions
    localparam int BHD_FEAT_RDLINE_BIT = 0;
    localparam int BHD_FEAT_RDMULT_BIT = 1;
    localparam int BHD_FEAT_MWI_BIT = 2;
    localparam int BHD_FEAT_EXTLEN_BIT = 3;
    // status register layout
    localparam int BHD_ST_EN_BIT = 0;
    localparam int BHD_ST_SLOT_LSB = 4;
    localparam int BHD_ST_SUBM_LSB = 8;
    localparam int BHD_ST_LAST_LSB = 12;
    localparam int BHD_ST_ID_LSB = 16;
    // read hint codes
    localparam logic [3:0] BHD_RH_1W = 4'h0;
    localparam logic [3:0] BHD_RH_2W = 4'h1;
    localparam logic [3:0] BHD_RH_4W = 4'h2;
    localparam logic [3:0] BHD_RH_8W = 4'h3;
    localparam logic [3:0] BHD_RH_16W = 4'h4;
    localparam logic [3:0] BHD_RH_24W = 4'h5;
    localparam logic [3:0] BHD_RH_HALF = 4'hB;
    localparam logic [3:0] BHD_RH_FULL = 4'hF;
    // write split codes
    localparam logic [1:0] BHD_WH_1W = 2'h0;
    localparam logic [1:0] BHD_WH_2W = 2'h1;
    localparam logic [1:0] BHD_WH_4W = 2'h2;
    localparam logic [1:0] BHD_WH_8W = 2'h3;
    // word counts on the system bus
    localparam logic [4:0] BHD_W1 = 5'h01;
    localparam logic [4:0] BHD_W2 = 5'h02;
    localparam logic [4:0] BHD_W4 = 5'h04;
    localparam logic [4:0] BHD_W8 = 5'h08;
    localparam logic [4:0] BHD_W16 = 5'h10;
    localparam logic [4:0] BHD_W24 = 5'h18;
    // pci commands
    localparam logic [3:0] BHD_CMD_MEM_RD = 4'h6;
    localparam logic [3:0] BHD_CMD_MEM_WR = 4'h7;
    localparam logic [3:0] BHD_CMD_RD_MULT = 4'hC;
    localparam logic [3:0] BHD_CMD_RD_LINE = 4'hE;
    localparam logic [3:0] BHD_CMD_MWI = 4'hF;

    typedef enum logic [1:0] {
        BHD_PF_FIXED = 2'b00,
        BHD_PF_HALF = 2'b01,
        BHD_PF_FULL = 2'b11
    } bhd_pf_mode_t;

    typedef enum logic [1:0] {
        BHD_CFG_UNSET = 2'b00,
        BHD_CFG_ARMED = 2'b01
    } bhd_cfg_state_t;
endpackage : bhd_pkg

// ===== shared/bhd_hint_if.sv
`timescale 1ns/1ns
`default_nettype none
interface bhd_hint_if;
    import bhd_pkg::*;
    logic [3:0] rd_code;
    logic [1:0] wr_code;
    logic [3:0] cmd;
    logic feat_rdline;
    logic feat_rdmult;
    logic feat_mwi;
    logic feat_extlen;
    logic is_read;
    logic is_write;
    logic [4:0] rd_words;
    bhd_pf_mode_t rd_mode;
    logic ext_hint;
    logic [4:0] wr_words;

    modport dec (
        input rd_code, wr_code, cmd, feat_rdline, feat_rdmult,
        input feat_mwi, feat_extlen,
        output is_read, is_write, rd_words, rd_mode, ext_hint, wr_words
    );
    modport user (
        output rd_code, wr_code, cmd, feat_rdline, feat_rdmult,
        output feat_mwi, feat_extlen,
        input is_read, is_write, rd_words, rd_mode, ext_hint, wr_words
    );
endinterface : bhd_hint_if
`default_nettype wire

// ===== verilog/bhd_hint_decode.sv
`timescale 1ns/1ns
`default_nettype none
module bhd_hint_decode
    import bhd_pkg::*;
(
    bhd_hint_if.dec hif
);
    logic [3:0] eff_code;

    // command class
    always_comb begin
        hif.is_read = (hif.cmd == BHD_CMD_MEM_RD) ||
            (hif.cmd == BHD_CMD_RD_MULT) || (hif.cmd == BHD_CMD_RD_LINE);
        hif.is_write = (hif.cmd == BHD_CMD_MEM_WR) ||
            (hif.cmd == BHD_CMD_MWI);
    end

    // command overrides beat the programmed field when enabled
    always_comb begin
        eff_code = hif.rd_code;
        if (hif.cmd == BHD_CMD_RD_LINE && hif.feat_rdline) begin
            eff_code = BHD_RH_24W;
        end else if (hif.cmd == BHD_CMD_RD_MULT && hif.feat_rdmult) begin
            eff_code = BHD_RH_FULL;
        end
    end

    // read prefetch table; unlisted codes fall back to one word
    always_comb begin
        hif.rd_words = BHD_W1;
        hif.rd_mode = BHD_PF_FIXED;
        hif.ext_hint = 1'b0;
        case (eff_code)
            BHD_RH_1W: hif.rd_words = BHD_W1;
            BHD_RH_2W: hif.rd_words = BHD_W2;
            BHD_RH_4W: hif.rd_words = BHD_W4;
            BHD_RH_8W: hif.rd_words = BHD_W8;
            BHD_RH_16W: begin
                hif.rd_words = BHD_W16;
                hif.ext_hint = hif.feat_extlen;
            end
            BHD_RH_24W: begin
                hif.rd_words = BHD_W24;
                hif.ext_hint = hif.feat_extlen;
            end
            BHD_RH_HALF: begin
                hif.rd_words = BHD_W24;
                hif.rd_mode = BHD_PF_HALF;
                hif.ext_hint = hif.feat_extlen;
            end
            BHD_RH_FULL: begin
                hif.rd_words = BHD_W24;
                hif.rd_mode = BHD_PF_FULL;
                hif.ext_hint = hif.feat_extlen;
            end
            default: hif.rd_words = BHD_W1;
        endcase
    end

    // write split size; invalidate writes go out as eight words when feat_mwi is set
    always_comb begin
        hif.wr_words = BHD_W1;
        if (hif.cmd == BHD_CMD_MWI && hif.feat_mwi) begin
            hif.wr_words = BHD_W8;
        end else begin
            case (hif.wr_code)
                BHD_WH_1W: hif.wr_words = BHD_W1;
                BHD_WH_2W: hif.wr_words = BHD_W2;
                BHD_WH_4W: hif.wr_words = BHD_W4;
                default: hif.wr_words = BHD_W8;
            endcase
        end
    end
endmodule : bhd_hint_decode
`default_nettype wire

// ===== verilog/bhd_bridge_cfg.sv
`timescale 1ns/1ns
`default_nettype none
module bhd_bridge_cfg
    import bhd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    // bus id broadcast
    input wire logic bcast_valid_in,
    input wire logic [9:0] bcast_bus_id_in,
    input wire logic [3:0] slot_addr_in,
    input wire logic [1:0] subm_id_in,
    // register access from the system bus
    input wire logic [31:0] sys_addr_in,
    input wire logic sys_wr_in,
    input wire logic sys_rd_in,
    input wire logic [31:0] sys_wdata_in,
    output logic sys_ack_out,
    output logic [31:0] sys_rdata_out,
    // upstream transaction start
    input wire logic txn_start_in,
    input wire logic [2:0] txn_master_in,
    input wire logic [3:0] txn_cmd_in,
    output logic txn_valid_out,
    output logic txn_is_read_out,
    output logic txn_is_write_out,
    output logic [2:0] txn_slot_out,
    output logic [4:0] rd_words_out,
    output logic [1:0] rd_mode_out,
    output logic extended_length_hint_out,
    output logic [4:0] wr_words_out,
    // arbiter routing
    output logic [5:0] ext_arb_sel_out,
    output logic regs_armed_out
);
    bhd_cfg_state_t cfg_state_reg;
    logic [9:0] bus_id_reg;
    logic [3:0] slot_reg;
    logic [1:0] subm_reg;
    logic [31:0] feature_enable_reg;
    logic [31:0] read_prefetch_hints_reg;
    logic [31:0] write_split_hints_reg;
    logic [5:0] ext_arb_reg;
    logic [2:0] last_slot_reg;
    logic space_hit;
    logic [11:0] reg_off;
    logic [31:0] rdata_next;
    logic [3:0] read_hint_slot_a;
    logic [3:0] read_hint_slot_b;
    logic [3:0] read_hint_slot_c;
    logic [3:0] read_hint_slot_d;
    logic [3:0] read_hint_slot_e;
    logic [3:0] read_hint_slot_f;
    logic [3:0] rd_field [BHD_NUM_SLOTS];
    logic [1:0] wr_field [BHD_NUM_SLOTS];
    logic slot_ok;
    logic [3:0] sel_rd_code;
    logic [1:0] sel_wr_code;
    logic direct_io_access;

    bhd_hint_if hif ();

    // bus id broadcast arms the register decoder
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            cfg_state_reg <= BHD_CFG_UNSET;
        end else begin
            case (cfg_state_reg)
                BHD_CFG_UNSET: begin
                    if (bcast_valid_in) begin
                        cfg_state_reg <= BHD_CFG_ARMED;
                    end
                end
                BHD_CFG_ARMED: cfg_state_reg <= BHD_CFG_ARMED;
                default: cfg_state_reg <= BHD_CFG_UNSET;
            endcase
        end
    end

    // a later broadcast simply reprograms the id
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            bus_id_reg <= 10'h000;
            slot_reg <= 4'h0;
            subm_reg <= 2'h0;
        end else if (bcast_valid_in) begin
            bus_id_reg <= bcast_bus_id_in;
            slot_reg <= slot_addr_in;
            subm_reg <= subm_id_in;
        end
    end

    // full address decode of the 4K register space
    always_comb begin
        space_hit =
            (sys_addr_in[31:BHD_SPACE_TOP_LSB] == BHD_SPACE_TOP) &&
            (sys_addr_in[BHD_SPACE_TOP_LSB-1:BHD_ID_LSB] == bus_id_reg) &&
            (sys_addr_in[BHD_ID_LSB-1:BHD_SLOT_LSB] == slot_reg) &&
            (sys_addr_in[BHD_SLOT_LSB-1:BHD_SUBM_LSB] == subm_reg);
        reg_off = sys_addr_in[BHD_OFF_W-1:0];
    end

    // nothing answers until the id is known; bus id is read-only, shown in status
    assign direct_io_access = (cfg_state_reg == BHD_CFG_ARMED) &&
        space_hit && (sys_wr_in || sys_rd_in);

    // feature enable word, every bit read/write
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            feature_enable_reg <= BHD_RST_FEAT;
        end else if (direct_io_access && sys_wr_in &&
                reg_off == BHD_OFF_FEAT) begin
            feature_enable_reg <= sys_wdata_in;
        end
    end

    // read hint fields; spare bits never store
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            read_prefetch_hints_reg <= BHD_RST_RDHINT;
        end else if (direct_io_access && sys_wr_in &&
                reg_off == BHD_OFF_RDHINT) begin
            read_prefetch_hints_reg <= sys_wdata_in & BHD_RDHINT_MASK;
        end
    end

    // write split fields; spare pairs read as zero
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            write_split_hints_reg <= BHD_RST_WRHINT;
        end else if (direct_io_access && sys_wr_in &&
                reg_off == BHD_OFF_WRHINT) begin
            write_split_hints_reg <= sys_wdata_in & BHD_WRHINT_MASK;
        end
    end

    // per-slot external arbiter routing
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            ext_arb_reg <= BHD_RST_EXTARB;
        end else if (direct_io_access && sys_wr_in &&
                reg_off == BHD_OFF_EXTARB) begin
            ext_arb_reg <= sys_wdata_in[BHD_NUM_SLOTS-1:0];
        end
    end

    // read-back mux; unmapped offsets read zero but still answer
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_off == BHD_OFF_FEAT) begin
            rdata_next = feature_enable_reg;
        end else if (reg_off == BHD_OFF_RDHINT) begin
            rdata_next = read_prefetch_hints_reg;
        end else if (reg_off == BHD_OFF_WRHINT) begin
            rdata_next = write_split_hints_reg;
        end else if (reg_off == BHD_OFF_EXTARB) begin
            rdata_next = {26'h000_0000, ext_arb_reg};
        end else if (reg_off == BHD_OFF_STATUS) begin
            rdata_next[BHD_ST_EN_BIT] = (cfg_state_reg == BHD_CFG_ARMED);
            rdata_next[BHD_ST_SLOT_LSB +: BHD_SLOT_W] = slot_reg;
            rdata_next[BHD_ST_SUBM_LSB +: BHD_SUBM_W] = subm_reg;
            rdata_next[BHD_ST_LAST_LSB +: BHD_MASTER_W] = last_slot_reg;
            rdata_next[BHD_ST_ID_LSB +: BHD_BUS_ID_W] = bus_id_reg;
        end
    end

    // one-cycle answer; rdata holds until the next read
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            sys_ack_out <= 1'b0;
            sys_rdata_out <= 32'h0000_0000;
        end else begin
            sys_ack_out <= direct_io_access;
            if (direct_io_access && sys_rd_in) begin
                sys_rdata_out <= rdata_next;
            end
        end
    end

    // named per-slot read fields
    assign read_hint_slot_a = rd_field[0];
    assign read_hint_slot_b = rd_field[1];
    assign read_hint_slot_c = rd_field[2];
    assign read_hint_slot_d = rd_field[3];
    assign read_hint_slot_e = rd_field[4];
    assign read_hint_slot_f = rd_field[5];

    // slice fields per slot, one generate for all six
    generate
        for (genvar s = 0; s < BHD_NUM_SLOTS; s++) begin : g_slot
            assign rd_field[s] =
                read_prefetch_hints_reg[s*BHD_FIELD_STRIDE +: BHD_RD_FIELD_W];
            assign wr_field[s] =
                write_split_hints_reg[s*BHD_FIELD_STRIDE +: BHD_WR_FIELD_W];
        end
    endgenerate

    // slot of the granted master picks its own fields
    always_comb begin
        slot_ok = (txn_master_in < 3'(BHD_NUM_SLOTS));
        sel_rd_code = BHD_RH_1W;
        sel_wr_code = BHD_WH_1W;
        case (txn_master_in)
            3'h0: sel_rd_code = read_hint_slot_a;
            3'h1: sel_rd_code = read_hint_slot_b;
            3'h2: sel_rd_code = read_hint_slot_c;
            3'h3: sel_rd_code = read_hint_slot_d;
            3'h4: sel_rd_code = read_hint_slot_e;
            3'h5: sel_rd_code = read_hint_slot_f;
            default: sel_rd_code = BHD_RH_1W;
        endcase
        if (slot_ok) begin
            sel_wr_code = wr_field[txn_master_in];
        end
    end

    // decoder fed from the selected slot and the feature bits
    assign hif.rd_code = sel_rd_code;
    assign hif.wr_code = sel_wr_code;
    assign hif.cmd = txn_cmd_in;
    assign hif.feat_rdline = feature_enable_reg[BHD_FEAT_RDLINE_BIT];
    assign hif.feat_rdmult = feature_enable_reg[BHD_FEAT_RDMULT_BIT];
    assign hif.feat_mwi = feature_enable_reg[BHD_FEAT_MWI_BIT];
    assign hif.feat_extlen = feature_enable_reg[BHD_FEAT_EXTLEN_BIT];

    bhd_hint_decode u_decode (
        .hif(hif.dec)
    );

    // transaction answer is latched once, at the start pulse
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            txn_valid_out <= 1'b0;
            txn_is_read_out <= 1'b0;
            txn_is_write_out <= 1'b0;
            txn_slot_out <= 3'h0;
            rd_words_out <= BHD_W1;
            rd_mode_out <= BHD_PF_FIXED;
            extended_length_hint_out <= 1'b0;
            wr_words_out <= BHD_W1;
        end else begin
            txn_valid_out <= txn_start_in && slot_ok;
            if (txn_start_in && slot_ok) begin
                txn_is_read_out <= hif.is_read;
                txn_is_write_out <= hif.is_write;
                txn_slot_out <= txn_master_in;
                rd_words_out <= hif.rd_words;
                rd_mode_out <= hif.rd_mode;
                extended_length_hint_out <= hif.ext_hint;
                wr_words_out <= hif.wr_words;
            end
        end
    end

    // last slot served, visible in status
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            last_slot_reg <= 3'h0;
        end else if (txn_start_in && slot_ok) begin
            last_slot_reg <= txn_master_in;
        end
    end

    // routing and armed flag, registered straight out
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            ext_arb_sel_out <= BHD_RST_EXTARB;
            regs_armed_out <= 1'b0;
        end else begin
            ext_arb_sel_out <= ext_arb_reg;
            regs_armed_out <= (cfg_state_reg == BHD_CFG_ARMED);
        end
    end
endmodule : bhd_bridge_cfg
`default_nettype wire

// ===== dv/bhd_cfg_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module bhd_cfg_checker
    import bhd_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic bcast_valid_in,
    input wire logic [9:0] bcast_bus_id_in,
    input wire logic [3:0] slot_addr_in,
    input wire logic [1:0] subm_id_in,
    input wire logic [31:0] sys_addr_in,
    input wire logic sys_wr_in,
    input wire logic sys_rd_in,
    input wire logic sys_ack_out,
    input wire logic txn_start_in,
    input wire logic [2:0] txn_master_in,
    input wire logic txn_valid_out,
    input wire logic [2:0] txn_slot_out,
    input wire logic [4:0] rd_words_out,
    input wire logic [1:0] rd_mode_out,
    input wire logic extended_length_hint_out,
    input wire logic [4:0] wr_words_out,
    input wire logic regs_armed_out
);
    logic [19:0] base_reg;
    // shadow of the programmed space address, no reset needed: unarmed
    always_ff @(posedge core_clk_in) begin
        if (bcast_valid_in) begin
            base_reg <= {4'hF, bcast_bus_id_in, slot_addr_in, subm_id_in};
        end
    end
    // access hit and accepted transaction start
    wire logic hit_w = (sys_wr_in | sys_rd_in)
        && sys_addr_in[31:12] == base_reg;
    wire logic go_w = txn_start_in && txn_master_in < 3'h6;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    a_hit_ack: assert property (
        regs_armed_out && hit_w |=> sys_ack_out)
        else $error("hit access not answered");
    a_ack_cause: assert property (sys_ack_out |-> $past(hit_w))
        else $error("answer without matching address");
    a_ack_armed: assert property (sys_ack_out |-> regs_armed_out)
        else $error("answer while unarmed");
    a_arm_cause: assert property (
        $rose(regs_armed_out) |-> $past(bcast_valid_in, 2))
        else $error("armed without broadcast");
    a_txn_answer: assert property (go_w |=> txn_valid_out)
        else $error("start not answered");
    a_txn_refuse: assert property (!go_w |=> !txn_valid_out)
        else $error("result without accepted start");
    a_txn_slot: assert property (
        go_w |=> txn_slot_out == $past(txn_master_in))
        else $error("slot differs from granted master");
    a_result_hold: assert property (
        !txn_valid_out |-> $stable({txn_slot_out, rd_words_out,
        rd_mode_out, wr_words_out}))
        else $error("results moved without a start");
    a_mode_words: assert property (
        txn_valid_out && rd_mode_out != 2'h0 |-> rd_words_out == 5'h18)
        else $error("fifo mode with wrong size");
    a_hint_long: assert property (
        txn_valid_out && extended_length_hint_out
        |-> rd_words_out inside {5'h10, 5'h18})
        else $error("extended hint on short fetch");
    a_wr_sizes: assert property (
        txn_valid_out |-> wr_words_out inside {5'h01, 5'h02, 5'h04, 5'h08})
        else $error("illegal write split");

    c_ack: cover property (sys_ack_out);
    c_arm: cover property ($rose(regs_armed_out));
    c_full: cover property (txn_valid_out && rd_mode_out == 2'h3);
    c_ext: cover property (txn_valid_out && extended_length_hint_out);
endmodule : bhd_cfg_checker

bind bhd_bridge_cfg bhd_cfg_checker i_chk (.core_clk_in, .srst_in,
    .bcast_valid_in, .bcast_bus_id_in, .slot_addr_in, .subm_id_in,
    .sys_addr_in, .sys_wr_in, .sys_rd_in, .sys_ack_out, .txn_start_in,
    .txn_master_in, .txn_valid_out, .txn_slot_out, .rd_words_out,
    .rd_mode_out, .extended_length_hint_out, .wr_words_out,
    .regs_armed_out);
`default_nettype wire

// ===== dv/bhd_pci_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module bhd_pci_master_model (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic req_in,
    input wire logic [2:0] master_in,
    input wire logic [3:0] cmd_in,
    output logic start_out,
    output logic [2:0] master_out,
    output logic [3:0] cmd_out
);
    // granted master shows its id and command with the start only
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            start_out <= 1'b0;
            master_out <= 3'h0;
            cmd_out <= 4'h0;
        end else begin
            start_out <= req_in;
            // idle lines keep moving so stale values cannot pass
            master_out <= req_in ? master_in : master_out + 3'h3;
            cmd_out <= req_in ? cmd_in : ~cmd_out;
        end
    end
endmodule : bhd_pci_master_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import bhd_pkg::*;
    logic clk, srst, bcv, swr, srd, ack, req, st, tv, isr, isw, xh, arm;
    logic seen;
    logic [9:0] bid;
    logic [3:0] sl, tc, cm;
    logic [1:0] sm, mode;
    logic [2:0] tm, mm, slot;
    logic [4:0] rw, ww;
    logic [5:0] xa;
    logic [31:0] adr, wd, rdat;
    logic [19:0] base;
    logic [19:0] flip [4] = '{20'h10000, 20'h00040, 20'h00004, 20'h00001};
    int fail_count, checks_done;

    bhd_bridge_cfg i_dut (.core_clk_in(clk), .srst_in(srst),
        .bcast_valid_in(bcv), .bcast_bus_id_in(bid), .slot_addr_in(sl),
        .subm_id_in(sm), .sys_addr_in(adr), .sys_wr_in(swr),
        .sys_rd_in(srd), .sys_wdata_in(wd), .sys_ack_out(ack),
        .sys_rdata_out(rdat), .txn_start_in(st), .txn_master_in(mm),
        .txn_cmd_in(cm), .txn_valid_out(tv), .txn_is_read_out(isr),
        .txn_is_write_out(isw), .txn_slot_out(slot), .rd_words_out(rw),
        .rd_mode_out(mode), .extended_length_hint_out(xh),
        .wr_words_out(ww), .ext_arb_sel_out(xa), .regs_armed_out(arm));
    bhd_pci_master_model i_pci (.clk_in(clk), .srst_in(srst),
        .req_in(req), .master_in(tm), .cmd_in(tc), .start_out(st),
        .master_out(mm), .cmd_out(cm));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one register access, sampled in the answer cycle
    task automatic acc(input logic w, input logic [11:0] off,
            input logic [31:0] d);
        @(posedge clk);
        swr <= w;
        srd <= ~w;
        adr <= {base, off};
        wd <= d;
        @(posedge clk);
        swr <= 1'b0;
        srd <= 1'b0;
        @(negedge clk);
    endtask : acc

    task automatic wchk(input logic [11:0] off, input logic [31:0] d);
        acc(1'b1, off, d);
        chk(32'(ack), 32'h1);
    endtask : wchk

    task automatic rchk(input logic [11:0] off, input logic [31:0] e);
        acc(1'b0, off, 32'h0);
        chk(32'(ack), 32'h1);
        chk(rdat, e);
    endtask : rchk

    task automatic bcast(input logic [9:0] id);
        @(posedge clk);
        bcv <= 1'b1;
        bid <= id;
        sl <= 4'h3;
        sm <= 2'h2;
        @(posedge clk);
        bcv <= 1'b0;
        bid <= ~id;
        sl <= 4'hC;
        sm <= 2'h1;
        repeat (2) @(negedge clk);
        base = {4'hF, id, 4'h3, 2'h2};
    endtask : bcast

    // start one upstream transaction and wait a bounded time for results
    task automatic txn(input logic [2:0] m, input logic [3:0] c);
        @(posedge clk);
        req <= 1'b1;
        tm <= m;
        tc <= c;
        @(posedge clk);
        req <= 1'b0;
        seen = 1'b0;
        for (int n = 0; n < 4 && !seen; n++) begin
            @(negedge clk);
            seen = tv;
        end
    endtask : txn

    // expected {hint, mode, words} for a read code
    function automatic logic [7:0] rexp(input logic [3:0] c, input logic x);
        case (c)
            4'h0, 4'h1, 4'h2, 4'h3: rexp = {3'h0, 5'h01 << c[1:0]};
            4'h4: rexp = {x, 7'h10};
            4'h5: rexp = {x, 7'h18};
            4'hB: rexp = {x, 7'h38};
            4'hF: rexp = {x, 7'h78};
            default: rexp = 8'h01;
        endcase
    endfunction : rexp

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #2_000_000;
        fail_count++;
        print_verdict();
    end

    initial begin
        {srst, bcv, swr, srd, req} = 5'h10;
        {bid, sl, sm, tm, tc} = 23'h0;
        adr = 32'h0;
        wd = 32'h0;
        fail_count = 0;
        checks_done = 0;
        base = {4'hF, 10'h2A5, 4'h3, 2'h2};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(32'({arm, tv, ack, xa, rw, ww}), 32'({9'h0, 10'h021}));
        // no answer before the bus id is programmed
        acc(1'b1, BHD_OFF_FEAT, 32'hFFFF_FFFF);
        chk(32'(ack), 32'h0);
        bcast(10'h2A5);
        chk(32'(arm), 32'h1);
        rchk(BHD_OFF_FEAT, 32'h0);
        rchk(BHD_OFF_RDHINT, 32'h0);
        rchk(BHD_OFF_WRHINT, 32'h0);
        wchk(BHD_OFF_FEAT, 32'hFFFF_FFFF);
        rchk(BHD_OFF_FEAT, 32'hFFFF_FFFF);
        wchk(BHD_OFF_RDHINT, 32'hFFFF_FFFF);
        rchk(BHD_OFF_RDHINT, BHD_RDHINT_MASK);
        wchk(BHD_OFF_WRHINT, 32'hFFFF_FFFF);
        rchk(BHD_OFF_WRHINT, BHD_WRHINT_MASK);
        wchk(BHD_OFF_EXTARB, 32'h2D);
        rchk(BHD_OFF_EXTARB, 32'h2D);
        chk(32'(xa), 32'h2D);
        rchk(12'h900, 32'h0);
        // each address field must match before anything answers
        foreach (flip[i]) begin
            base ^= flip[i];
            acc(1'b0, BHD_OFF_FEAT, 32'h0);
            chk(32'(ack), 32'h0);
            base ^= flip[i];
        end
        // every read code, extended hint disabled then enabled
        for (int x = 0; x < 2; x++) begin
            wchk(BHD_OFF_FEAT, 32'(x) << 3);
            for (int c = 0; c < 16; c++) begin
                wchk(BHD_OFF_RDHINT, 32'(c));
                txn(3'h0, BHD_CMD_MEM_RD);
                chk(32'({seen, isr, isw, xh, mode, rw}),
                    32'({3'h6, rexp(4'(c), x[0])}));
            end
        end
        // each slot picks its own fields
        wchk(BHD_OFF_FEAT, 32'h0);
        wchk(BHD_OFF_RDHINT, 32'h0054_3210);
        wchk(BHD_OFF_WRHINT, 32'h0010_3210);
        for (int m = 0; m < 6; m++) begin
            txn(3'(m), BHD_CMD_MEM_WR);
            chk(32'({slot, isw, xh, mode, rw, ww}),
                32'({3'(m), 1'b1, rexp(4'(m), 1'b0), 5'h01 << (m % 4)}));
        end
        // status: armed, slot 3, submodule 2, last slot 5, id 2A5
        rchk(BHD_OFF_STATUS, 32'h02A5_5231);
        // command overrides, disabled then enabled
        for (int x = 0; x < 2; x++) begin
            wchk(BHD_OFF_FEAT, x ? 32'h7 : 32'h0);
            txn(3'h0, BHD_CMD_RD_LINE);
            chk(32'({xh, mode, rw}),
                32'(rexp(x ? 4'h5 : 4'h0, 1'b0)));
            txn(3'h0, BHD_CMD_RD_MULT);
            chk(32'({xh, mode, rw}),
                32'(rexp(x ? 4'hF : 4'h0, 1'b0)));
            txn(3'h0, BHD_CMD_MWI);
            chk(32'({isw, ww}), 32'({1'b1, x ? 5'h08 : 5'h01}));
        end
        // masters beyond the six slots are ignored
        for (int m = 6; m < 8; m++) begin
            txn(3'(m), BHD_CMD_MEM_WR);
            chk(32'({seen, slot, ww}), 32'({4'h0, 5'h08}));
        end
        // a new bus id moves the registers but not the forwarding
        bcast(10'h15A);
        rchk(BHD_OFF_FEAT, 32'h7);
        txn(3'h0, BHD_CMD_RD_LINE);
        chk(32'({xh, mode, rw}), 32'(rexp(4'h5, 1'b0)));
        print_verdict();
    end
endmodule : tb
`default_nettype wire
